// ---- core/synth_divider_config_port.sv ----
// configuration port, dividers and diagnostic mux of the synthesizer
`timescale 1ns/1ps
`include "synth_regs.svh"
module synth_divider_config_port
    import synth_pkg::*;
#(
    parameter int CNT_W = 10
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic parallelLoadPin,
    input wire logic serialLatchPin,
    input wire logic serialClockPin,
    input wire logic serialDataPin,
    input wire logic [`M_W-1:0] feedbackDividePins,
    input wire logic [`N_W-1:0] postDividePins,
    input wire logic crystalPin,
    input wire logic vcoPin,
    output logic synthClockOut,
    output logic diagOut,
    output logic feedbackClockOut,
    output logic refClockOut,
    output logic [`M_W-1:0] feedbackDivide,
    output logic [3:0] postRatio,
    output logic [`T_W-1:0] diagSelect,
    output logic bypassMode,
    output logic spreadEnable,
    output logic spreadDown,
    output logic [2:0] spreadAmount
);

    localparam int PIN_W = 6 + `M_W + `N_W;
    localparam int P_PLOAD = PIN_W - 1;
    localparam int P_SLATCH = PIN_W - 2;
    localparam int P_SCLK = PIN_W - 3;
    localparam int P_SDATA = PIN_W - 4;
    localparam int P_XTAL = PIN_W - 5;
    localparam int P_VCO = PIN_W - 6;

    // ratio 1,2,4,8 from the two-bit select
    function automatic logic [CNT_W-1:0] post_ratio(input logic [`N_W-1:0] sel);
        post_ratio = CNT_W'(1) << sel;
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    wire logic [PIN_W-1:0] pinRaw;
    logic [PIN_W-1:0] syncA_reg;
    logic [PIN_W-1:0] syncB_reg;
    logic [PIN_W-1:0] syncC_reg;
    logic [PIN_W-1:0] pinFilt_reg;
    logic [PIN_W-1:0] pinPrev_reg;

    assign pinRaw = {parallelLoadPin, serialLatchPin, serialClockPin, serialDataPin, crystalPin, vcoPin,
                     feedbackDividePins, postDividePins};

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            syncA_reg <= '0;
            syncB_reg <= '0;
            syncC_reg <= '0;
            pinPrev_reg <= '0;
        end
        else
        begin
            syncA_reg <= pinRaw;
            syncB_reg <= syncA_reg;
            syncC_reg <= syncB_reg;
            pinPrev_reg <= pinFilt_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < PIN_W; gi++)
        begin : gen_filter
            always_ff @(posedge sys_clk)
            begin
                if (rst)
                begin
                    pinFilt_reg[gi] <= 1'b0;
                end
                else if (syncB_reg[gi] == syncC_reg[gi])
                begin
                    pinFilt_reg[gi] <= syncC_reg[gi];
                end
            end
        end
    endgenerate

    // ****************************************
    // decoded pin events
    // ****************************************
    wire logic ploadHigh;
    wire logic ploadRise;
    wire logic latchFall;
    wire logic sclkRise;
    wire logic sdataBit;
    wire logic xtalRise;
    wire logic vcoRise;
    wire logic [`M_W-1:0] mPins;
    wire logic [`N_W-1:0] nPins;

    assign ploadHigh = pinFilt_reg[P_PLOAD];
    assign ploadRise = pinFilt_reg[P_PLOAD] & ~pinPrev_reg[P_PLOAD];
    assign latchFall = ~pinFilt_reg[P_SLATCH] & pinPrev_reg[P_SLATCH];
    assign sclkRise = pinFilt_reg[P_SCLK] & ~pinPrev_reg[P_SCLK];
    assign sdataBit = pinFilt_reg[P_SDATA];
    assign xtalRise = pinFilt_reg[P_XTAL] & ~pinPrev_reg[P_XTAL];
    assign vcoRise = pinFilt_reg[P_VCO] & ~pinPrev_reg[P_VCO];
    assign mPins = pinFilt_reg[`N_W +: `M_W];
    assign nPins = pinFilt_reg[`N_W-1:0];

    // ****************************************
    // serial shift register
    // ****************************************
    logic [`STREAM_W-1:0] shift_reg;
    logic [`STREAM_W-1:0] shift_next;
    wire logic shiftEn;

    assign shiftEn = ploadHigh & sclkRise;
    assign shift_next = shiftEn ? {shift_reg[`STREAM_W-2:0], sdataBit} : shift_reg;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            shift_reg <= '0;
        end
        else
        begin
            shift_reg <= shift_next;
        end
    end

    // ****************************************
    // configuration latches
    // ****************************************
    logic [`M_W-1:0] latchM_reg;
    logic [`N_W-1:0] latchN_reg;
    logic [`T_W-1:0] latchT_reg;
    logic [`SS_W-1:0] latchSS_reg;
    logic [`M_W-1:0] latchM_next;
    logic [`N_W-1:0] latchN_next;
    logic [`T_W-1:0] latchT_next;
    logic [`SS_W-1:0] latchSS_next;
    wire logic serialXfer;

    assign serialXfer = ploadHigh & latchFall & ~ploadRise;

    // parallel strobe has priority; low strobe presets diag and spread
    assign latchM_next = ploadRise ? mPins : (serialXfer ? shift_reg[`M_HI:`M_LO] : latchM_reg);
    assign latchN_next = ploadRise ? nPins : (serialXfer ? shift_reg[`N_HI:`N_LO] : latchN_reg);
    assign latchT_next = !ploadHigh ? `T_RESET : (serialXfer ? shift_reg[`T_HI:`T_LO] : latchT_reg);
    assign latchSS_next = (!ploadHigh || ploadRise) ? `SS_RESET :
                          (serialXfer ? shift_reg[`SS_HI:`SS_LO] : latchSS_reg);

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            latchM_reg <= `M_RESET;
            latchN_reg <= `N_RESET;
            latchT_reg <= `T_RESET;
            latchSS_reg <= `SS_RESET;
        end
        else
        begin
            latchM_reg <= latchM_next;
            latchN_reg <= latchN_next;
            latchT_reg <= latchT_next;
            latchSS_reg <= latchSS_next;
        end
    end

    // ****************************************
    // active divide values
    // ****************************************
    logic [`M_W-1:0] activeM_reg;
    logic [`N_W-1:0] activeN_reg;
    wire logic [`M_W-1:0] activeM_next;
    wire logic [`N_W-1:0] activeN_next;

    assign activeM_next = ploadHigh ? latchM_next : mPins;
    assign activeN_next = ploadHigh ? latchN_next : nPins;

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            activeM_reg <= `M_RESET;
            activeN_reg <= `N_RESET;
        end
        else
        begin
            activeM_reg <= activeM_next;
            activeN_reg <= activeN_next;
        end
    end

    // ****************************************
    // dividers
    // ****************************************
    wire logic isBypass;
    wire logic divTick;
    wire logic [CNT_W-1:0] ratioN;
    wire logic [CNT_W-1:0] postHalf;
    wire logic [CNT_W-1:0] fbHalf;
    wire logic postOut;
    wire logic fbOut;
    wire logic refOut;
    wire logic quarterOut;
    logic synthPrev_reg;
    wire logic synthRise;

    assign isBypass = (latchT_reg == DIAG_BYPASS);
    assign divTick = isBypass ? sclkRise : vcoRise;
    assign ratioN = post_ratio(activeN_reg);
    // vco is 2N times the output; bypass halves the ratio, never below one
    assign postHalf = isBypass ? ((ratioN > CNT_W'(1)) ? (ratioN >> 1) : CNT_W'(1)) : ratioN;
    assign fbHalf = isBypass ? CNT_W'(post_ratio(activeN_reg) * `BYPASS_FB_MULT) : CNT_W'(activeM_reg);

    divider_counter #(.CNT_W(CNT_W)) postDivider
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(divTick),
        .halfCount(postHalf),
        .pulseMode(1'b0),
        .divOut(postOut)
    );

    divider_counter #(.CNT_W(CNT_W)) feedbackDivider
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(divTick),
        .halfCount(fbHalf),
        .pulseMode(isBypass),
        .divOut(fbOut)
    );

    divider_counter #(.CNT_W(CNT_W)) refDivider
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(xtalRise),
        .halfCount(`REF_HALF),
        .pulseMode(1'b0),
        .divOut(refOut)
    );

    assign synthRise = postOut & ~synthPrev_reg;

    divider_counter #(.CNT_W(CNT_W)) quarterDivider
    (
        .sys_clk(sys_clk),
        .rst(rst),
        .tick(synthRise),
        .halfCount(`QUARTER_HALF),
        .pulseMode(1'b0),
        .divOut(quarterOut)
    );

    // ****************************************
    // diagnostic mux
    // ****************************************
    logic diag_reg;
    logic diag_next;

    always_comb
    begin
        case (diag_sel_type'(latchT_reg))
            DIAG_SHIFT_OUT: diag_next = shift_reg[`STREAM_W-1];
            DIAG_ONE: diag_next = 1'b1;
            DIAG_REF: diag_next = refOut;
            DIAG_FEEDBACK: diag_next = fbOut;
            DIAG_SYNTH: diag_next = postOut;
            DIAG_ZERO: diag_next = 1'b0;
            DIAG_BYPASS: diag_next = fbOut;
            DIAG_QUARTER: diag_next = quarterOut;
            default: diag_next = 1'b0;
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            diag_reg <= 1'b0;
            synthPrev_reg <= 1'b0;
        end
        else
        begin
            diag_reg <= diag_next;
            synthPrev_reg <= postOut;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign synthClockOut = postOut;
    assign diagOut = diag_reg;
    assign feedbackClockOut = fbOut;
    assign refClockOut = refOut;
    assign feedbackDivide = activeM_reg;
    assign postRatio = ratioN[3:0];
    assign diagSelect = latchT_reg;
    assign bypassMode = isBypass;
    assign spreadEnable = (latchSS_reg[2:0] != 3'h0);
    assign spreadDown = latchSS_reg[3];
    assign spreadAmount = latchSS_reg[2:0];

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    diag_quiet_a: assert property (!ploadHigh |=> diagSelect == `T_RESET)
        else $error("diag select not forced quiet");

    spread_clear_a: assert property ((!ploadHigh || ploadRise) |=> latchSS_reg == `SS_RESET)
        else $error("spread bits not cleared by parallel load");

    par_capture_a: assert property (ploadRise |=> latchM_reg == $past(mPins) && latchN_reg == $past(nPins))
        else $error("parallel capture wrong");

    transparent_a: assert property (!ploadHigh ##1 !$past(ploadHigh) |-> feedbackDivide == $past(mPins))
        else $error("latch not transparent");

    shift_step_a: assert property (shiftEn |=> shift_reg == {$past(shift_reg[`STREAM_W-2:0]), $past(sdataBit)})
        else $error("shift register did not advance");

    no_shift_a: assert property (!ploadHigh |=> $stable(shift_reg))
        else $error("shift while parallel strobe low");

    serial_xfer_a: assert property (serialXfer |=> latchM_reg == $past(shift_reg[`M_HI:`M_LO])
                                    && latchT_reg == $past(shift_reg[`T_HI:`T_LO]))
        else $error("serial transfer wrong");

    diag_const_a: assert property (latchT_reg == 3'h1 |=> diagOut || $past(latchT_reg) != 3'h1)
        else $error("diag constant one missing");

    ratio_map_a: assert property (activeN_reg == 2'h3 |-> postRatio == 4'h8)
        else $error("post ratio mapping wrong");

    bypass_src_a: assert property (isBypass |-> divTick == sclkRise
                                   && fbHalf == CNT_W'(postRatio) * CNT_W'(`BYPASS_FB_MULT))
        else $error("bypass source wrong");

endmodule

// ---- shared/synth_regs.svh ----
// field layout, divider counts and reset values of the synthesizer configuration port
// Overview of operation
// - output is crystal/16 times M over N
// - post select 00..11 gives 1,2,4,8
// - parallel strobe rise captures M and N
// - parallel strobe low makes latches transparent
// - shift clock samples serial data into register
// - serial loading only while parallel strobe high
// - stream order: spread, diag, post, feedback
// - each field shifted most significant bit first
// - serial latch fall transfers register to latches
// - diag select set only by serial stream
// - parallel strobe low forces diag select 000
// - diag codes pick the diagnostic output source
// - diag 110 bypass: shift clock feeds dividers
// - bypass feedback output is shiftclock/(4*N)
// - bypass main output shiftclock/N, minimum two
// - frequency step is crystal/16 over N
// - shift register advances on shift clock rise
// - parallel load clears spread bits to 0000
// - spread off when low bits zero; msb type
`ifndef SYNTH_REGS_SVH
`define SYNTH_REGS_SVH

// ****************************************
// serial stream layout
// ****************************************
`define STREAM_W 18
`define SS_HI 17
`define SS_LO 14
`define T_HI 13
`define T_LO 11
`define N_HI 10
`define N_LO 9
`define M_HI 8
`define M_LO 0

// ****************************************
// widths and reset values
// ****************************************
`define M_W 9
`define N_W 2
`define T_W 3
`define SS_W 4
`define SS_RESET 4'h0
`define T_RESET 3'h0
`define N_RESET 2'h3
`define M_RESET 9'h1ff

// ****************************************
// divider counts
// ****************************************
`define REF_HALF 10'h008
`define QUARTER_HALF 10'h002
`define BYPASS_FB_MULT 4'h4

`endif

// ---- shared/synth_pkg.sv ----
// types of the synthesizer configuration port
package synth_pkg;

    typedef enum logic [2:0]
    {
        DIAG_SHIFT_OUT = 3'h0,
        DIAG_ONE = 3'h1,
        DIAG_REF = 3'h2,
        DIAG_FEEDBACK = 3'h3,
        DIAG_SYNTH = 3'h4,
        DIAG_ZERO = 3'h5,
        DIAG_BYPASS = 3'h6,
        DIAG_QUARTER = 3'h7
    } diag_sel_type;

endpackage

// ---- core/divider_counter.sv ----
// tick-driven divider: toggle or narrow-pulse output
`timescale 1ns/1ps
module divider_counter
    import synth_pkg::*;
#(
    parameter int CNT_W = 10
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic tick,
    input wire logic [CNT_W-1:0] halfCount,
    input wire logic pulseMode,
    output logic divOut
);

    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic out_reg;
    logic out_next;
    wire logic atEnd;

    // ****************************************
    // counting
    // ****************************************
    assign atEnd = (count_reg >= halfCount - CNT_W'(1));
    assign count_next = !tick ? count_reg : (atEnd ? '0 : count_reg + CNT_W'(1));
    assign out_next = !tick ? out_reg : (pulseMode ? (count_reg == '0) : (atEnd ? ~out_reg : out_reg));

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            count_reg <= '0;
            out_reg <= 1'b0;
        end
        else
        begin
            count_reg <= count_next;
            out_reg <= out_next;
        end
    end

    assign divOut = out_reg;

endmodule

// ---- tb/synth_ctrl_model.sv ----
// board controller model driving the configuration pins
`timescale 1ns/1ps
module synth_ctrl_model
(
    input wire logic sys_clk,
    output logic pLoad,
    output logic sLatch,
    output logic sClk,
    output logic sData,
    output logic [8:0] mPins,
    output logic [1:0] nPins
);
    // ****************************************
    // pin drivers
    // ****************************************
    initial
    begin
        pLoad = 1'b0;
        sLatch = 1'b0;
        sClk = 1'b0;
        sData = 1'b0;
        mPins = 9'h1ff;
        nPins = 2'h3;
    end

    task automatic step(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask

    // pins settle before the strobe level changes
    task automatic par(input logic [8:0] m, input logic [1:0] n, input logic p);
        mPins = m;
        nPins = n;
        step(6);
        pLoad = p;
        step(6);
    endtask

    // caller keeps the parallel strobe high for serial loads
    task automatic shift(input logic [17:0] w);
        for (int i = 17; i >= 0; i--)
        begin
            sData = w[i];
            step(5);
            sClk = 1'b1;
            step(5);
            sClk = 1'b0;
        end
        // released data line no longer shows the last bit
        sData = ~w[0];
        step(5);
    endtask

    task automatic latch();
        sLatch = 1'b1;
        step(6);
        sLatch = 1'b0;
        step(12);
    endtask
endmodule

// ---- tb/tb_synth_divider_config_port.sv ----
// self-checking bench of the synthesizer configuration port
`timescale 1ns/1ps
`include "synth_regs.svh"
module tb_synth_divider_config_port;
    import synth_pkg::*;
    logic sys_clk, rst, pLoad, sLatch, sClk, sData;
    logic [8:0] mPins;
    logic [1:0] nPins;
    logic [7:0] tickCnt;
    logic synthClockOut, diagOut, feedbackClockOut, refClockOut, bypassMode, spreadEnable, spreadDown;
    logic [8:0] feedbackDivide;
    logic [3:0] postRatio;
    logic [2:0] diagSelect, spreadAmount;
    logic [23:0] cur, got;
    logic [23:0] q[$];
    logic [17:0] w, wLast;
    logic [8:0] m;
    logic [1:0] n;
    logic [3:0] s;
    event chk;
    int n_mismatch = 0;
    int num_checks = 0;

    synth_ctrl_model i_ctrl (.sys_clk(sys_clk), .pLoad(pLoad), .sLatch(sLatch), .sClk(sClk),
        .sData(sData), .mPins(mPins), .nPins(nPins));

    synth_divider_config_port i_dut (.sys_clk(sys_clk), .rst(rst), .parallelLoadPin(pLoad),
        .serialLatchPin(sLatch), .serialClockPin(sClk), .serialDataPin(sData),
        .feedbackDividePins(mPins), .postDividePins(nPins), .crystalPin(tickCnt[3]),
        .vcoPin(tickCnt[2]), .synthClockOut(synthClockOut), .diagOut(diagOut),
        .feedbackClockOut(feedbackClockOut), .refClockOut(refClockOut),
        .feedbackDivide(feedbackDivide), .postRatio(postRatio), .diagSelect(diagSelect),
        .bypassMode(bypassMode), .spreadEnable(spreadEnable), .spreadDown(spreadDown),
        .spreadAmount(spreadAmount));

    // ****************************************
    // clock, pin ticks, checker, closing
    // ****************************************
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial tickCnt = 8'h00;
    always @(posedge sys_clk)
    begin
        #1;
        tickCnt <= tickCnt + 8'h01;
    end

    function automatic logic [21:0] pack(logic [8:0] fm, logic [1:0] fn, logic [2:0] ft, logic [3:0] fs);
        return {fm, 4'h1 << fn, ft, ft == 3'h6, fs[2:0] != 3'h0, fs[3], fs[2:0]};
    endfunction

    task automatic note(input logic [21:0] e, input logic u, input logic d);
        q.push_back({u, d, e});
        ->chk;
        i_ctrl.step(1);
    endtask

    // cycles between two rises of a clock output: 0 ref, 1 synth, 2 feedback, 3 diag
    task automatic period(input int k, input int want);
        logic [3:0] v;
        logic pv;
        int c;
        int r;
        c = 0;
        r = 0;
        pv = 1'b1;
        while (r < 2)
        begin
            i_ctrl.step(1);
            v = {diagOut, feedbackClockOut, synthClockOut, refClockOut};
            if (r > 0)
                c++;
            if (v[k] && !pv)
                r++;
            pv = v[k];
        end
        num_checks++;
        if (c != want)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t exp %h got %h", $time, want, c);
        end
    endtask

    always
    begin
        @(chk);
        cur = q.pop_front();
        got = {cur[23], cur[23] & diagOut, feedbackDivide, postRatio, diagSelect, bypassMode,
            spreadEnable, spreadDown, spreadAmount};
        num_checks++;
        if (got !== cur)
        begin
            n_mismatch++;
            $display("CHECK FAILED at %0t exp %h got %h", $time, cur, got);
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_mismatch++;
        end_of_test();
    end

    // ****************************************
    // tests
    // ****************************************
    initial
    begin
        rst = 1'b1;
        void'($urandom(11833));
        i_ctrl.step(4);
        rst = 1'b0;
        // filtered pins need five edges before the transparent path shows them
        i_ctrl.step(6);
        note(pack(9'h1ff, 2'h3, 3'h0, 4'h0), 1'b0, 1'b0); // reset values
        $display("test reset done");
        for (int i = 0; i < 4; i++)
        begin
            m = $urandom;
            i_ctrl.par(m, i[1:0], 1'b0);
            note(pack(m, i[1:0], 3'h0, 4'h0), 1'b0, 1'b0);
        end
        $display("test transparent done");
        m = $urandom;
        n = $urandom;
        i_ctrl.par(m, n, 1'b1);
        note(pack(m, n, 3'h0, 4'h0), 1'b0, 1'b0);
        i_ctrl.par(~m, ~n, 1'b1);
        note(pack(m, n, 3'h0, 4'h0), 1'b0, 1'b0);
        $display("test capture done");
        m = 9'h008 + 9'($urandom % 32);
        n = $urandom;
        i_ctrl.par(m, n, 1'b0);
        period(0, 256);
        period(1, 16 << n);
        period(2, 16 * m);
        i_ctrl.par(m, n, 1'b1);
        $display("test dividers done");
        for (int t = 0; t < 8; t++)
        begin
            s = $urandom;
            m = $urandom;
            n = $urandom;
            w = {s, t[2:0], n, m};
            i_ctrl.shift(w);
            i_ctrl.latch();
            note(pack(m, n, t[2:0], s), t == 1 || t == 5, t == 1);
        end
        period(3, 64 << n);
        wLast = w;
        $display("test serial done");
        m = $urandom;
        n = $urandom;
        i_ctrl.par(m, n, 1'b0);
        note(pack(m, n, 3'h0, 4'h0), 1'b0, 1'b0);
        $display("test strobe low done");
        w = $urandom;
        i_ctrl.shift(w);
        i_ctrl.par(m, n, 1'b1);
        i_ctrl.latch();
        note(pack(wLast[8:0], wLast[10:9], wLast[13:11], wLast[17:14]), 1'b0, 1'b0);
        $display("test shift refused done");
        end_of_test();
    end
endmodule
